// file: design/tdm_err_pkg.sv
package tdm_err_pkg;

  // ==========================================================
  // Sizes
  localparam int NUM_CH = 2;
  localparam int Q_DEPTH = 16;
  localparam logic [4:0] Q_FULL = 5'h10;
  localparam logic [7:0] MIN_SIZE = 8'h08;

  // ==========================================================
  // Error codes
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_RX_OVR_START = 8'h01;
  localparam logic [7:0] ERR_RX_OVR_MID = 8'h02;
  localparam logic [7:0] ERR_RX_MAP = 8'h03;
  localparam logic [7:0] ERR_RX_SIZE = 8'h05;
  localparam logic [7:0] ERR_TX_CID = 8'h10;
  localparam logic [7:0] ERR_TX_UND_START = 8'h11;
  localparam logic [7:0] ERR_TX_UND_MID = 8'h12;
  localparam logic [7:0] ERR_TX_MAP = 8'h13;
  localparam logic [7:0] ERR_TX_SIZE = 8'h15;
  localparam logic [7:0] ERR_RD_BASE = 8'hf0;
  localparam logic [7:0] ERR_WR_BASE = 8'hf8;

  // ==========================================================
  // Register map
  localparam logic [7:0] ADDR_GCTRL = 8'h00;
  localparam logic [7:0] ADDR_GSTAT = 8'h04;
  localparam logic [7:0] CH_BASE = 8'h10;
  localparam logic [7:0] CH_STRIDE = 8'h10;
  localparam logic [7:0] OFS_QCTRL = 8'h00;
  localparam logic [7:0] OFS_QCOUNT = 8'h04;
  localparam logic [7:0] OFS_QTOP = 8'h08;
  localparam int ENDIAN_BIT = 0;
  localparam int OVF_BIT = 0;
  localparam int DELAY_LSB = 4;
  localparam logic [7:0] GCTRL_RESET = 8'h00;

  // ==========================================================
  // Framing
  localparam int BITS_PER_SLOT = 8;
  localparam int SLOTS_PER_FRAME = 128;
  localparam logic [9:0] LAST_BIT = 10'(BITS_PER_SLOT * SLOTS_PER_FRAME - 1);
  localparam int CLK_NS = 50;
  localparam int STALL_NS = 3200;
  localparam logic [6:0] STALL_CYC = 7'(STALL_NS / CLK_NS);

  // Packing kinds
  localparam logic [1:0] PK_BYTES = 2'h0;
  localparam logic [1:0] PK_HALVES = 2'h1;
  localparam logic [1:0] PK_SYNC = 2'h2;

  typedef enum logic [2:0] {FR_WAIT, FR_DELAY, FR_RUN, FR_STALL, FR_RECOVER} fr_state_t;

  typedef struct packed {
    logic [7:0] code;
    logic [23:0] info;
  } entry_t;

  typedef struct packed {
    logic rx_nonempty;
    logic rx_full;
    logic rx_store_req;
    logic [7:0] rx_need;
    logic [7:0] rx_size;
    logic rx_cid_bad;
    logic tx_empty;
    logic tx_load_req;
    logic [7:0] tx_need;
    logic [7:0] tx_size;
    logic tx_fetch_vld;
    logic [7:0] tx_fetched_id;
    logic [7:0] active_id;
  } ch_in_t;

  typedef struct packed {
    logic done;
    logic write;
    logic ch;
    logic [2:0] status;
  } xfer_t;

  typedef struct packed {
    entry_t [Q_DEPTH-1:0] mem;
    logic [3:0] rd_ptr;
    logic [4:0] count;
    logic ovf;
    logic irq;
  } queue_t;

  typedef struct packed {
    logic req;
    logic [1:0] kind;
    logic [31:0] data;
  } pack_t;

endpackage

// file: design/tdm_err_recovery.sv
`timescale 1ns/1ps

module tdm_err_recovery (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  // Serial link pins
  input wire logic ser_clk,
  input wire logic frame_sync,
  // Channel and transfer status
  input wire tdm_err_pkg::ch_in_t [tdm_err_pkg::NUM_CH-1:0] ch_status,
  input wire tdm_err_pkg::xfer_t xfer,
  // Buffer packing path
  input wire tdm_err_pkg::pack_t pack_in,
  output logic [31:0] pack_out,
  output logic pack_vld,
  // Framing and interrupts
  output logic frame_start,
  output logic slot_tick,
  output logic data_corrupt,
  output logic [tdm_err_pkg::NUM_CH-1:0] err_irq
);

  // ==========================================================
  // State
  typedef struct packed {
    logic sclk_s1;
    logic sclk_s2;
    logic sclk_s3;
    logic fs_s1;
    logic fs_s2;
    tdm_err_pkg::fr_state_t fr_state;
    logic [9:0] bit_cnt;
    logic [3:0] dly_cnt;
    logic [6:0] idle_cnt;
    logic [23:0] frame_cnt;
    logic frame_start;
    logic slot_tick;
    logic corrupt;
    logic [7:0] gctrl;
    logic [31:0] rd_data;
    logic [31:0] pack_out;
    logic pack_vld;
    tdm_err_pkg::queue_t [tdm_err_pkg::NUM_CH-1:0] q;
  } state_t;

  state_t state_reg;
  state_t state_next;

  // ==========================================================
  // Error selection, one entry per channel per cycle
  function automatic tdm_err_pkg::entry_t pick_err(input tdm_err_pkg::ch_in_t ci, input logic fs,
                                                   input tdm_err_pkg::xfer_t xf, input logic mine,
                                                   input logic [23:0] frc);
    tdm_err_pkg::entry_t e;
    e = '0;
    if (xf.done && mine && xf.status != 3'h0) begin
      e.code = (xf.write ? tdm_err_pkg::ERR_WR_BASE : tdm_err_pkg::ERR_RD_BASE) + {5'h00, xf.status};
    end else if (ci.tx_fetch_vld && ci.tx_fetched_id != ci.active_id) begin
      e = {tdm_err_pkg::ERR_TX_CID, 8'h00, ci.active_id, ci.tx_fetched_id};
    end else if (ci.rx_store_req && ci.rx_full) begin
      e = {tdm_err_pkg::ERR_RX_OVR_MID, frc};
    end else if (ci.tx_load_req && ci.tx_empty) begin
      e = {tdm_err_pkg::ERR_TX_UND_MID, frc};
    end else if (ci.rx_cid_bad) begin
      e = {tdm_err_pkg::ERR_RX_MAP, 16'h0000, ci.active_id};
    end else if (fs) begin
      // Frame-start checks, most serious first
      if (ci.rx_nonempty) begin
        e = {tdm_err_pkg::ERR_RX_OVR_START, frc};
      end else if (ci.tx_empty) begin
        e = {tdm_err_pkg::ERR_TX_UND_START, frc};
      end else if (ci.rx_size < tdm_err_pkg::MIN_SIZE) begin
        e = {tdm_err_pkg::ERR_RX_SIZE, 16'h0000, ci.active_id};
      end else if (ci.rx_need > ci.rx_size) begin
        e = {tdm_err_pkg::ERR_RX_MAP, 16'h0000, ci.active_id};
      end else if (ci.tx_size < tdm_err_pkg::MIN_SIZE) begin
        e = {tdm_err_pkg::ERR_TX_SIZE, 16'h0000, ci.active_id};
      end else if (ci.tx_need > ci.tx_size) begin
        e = {tdm_err_pkg::ERR_TX_MAP, 16'h0000, ci.active_id};
      end
    end
    return e;
  endfunction

  // ==========================================================
  // Next-state logic
  always_comb begin
    logic sclk_rise;
    logic fs_hi;
    logic [7:0] base;
    logic pop;
    logic push;
    logic has_err;
    logic [3:0] wr_idx;
    tdm_err_pkg::entry_t err;
    sclk_rise = 1'b0;
    fs_hi = 1'b0;
    base = 8'h00;
    pop = 1'b0;
    push = 1'b0;
    has_err = 1'b0;
    wr_idx = 4'h0;
    err = '0;
    state_next = state_reg;
    state_next.frame_start = 1'b0;
    state_next.slot_tick = 1'b0;
    state_next.rd_data = 32'h0000_0000;
    state_next.pack_vld = 1'b0;

    // Pin synchronisers; edge seen on second and third stages
    state_next.sclk_s1 = ser_clk;
    state_next.sclk_s2 = state_reg.sclk_s1;
    state_next.sclk_s3 = state_reg.sclk_s2;
    state_next.fs_s1 = frame_sync;
    state_next.fs_s2 = state_reg.fs_s1;
    sclk_rise = state_reg.sclk_s2 & ~state_reg.sclk_s3;
    fs_hi = state_reg.fs_s2;

    // Stall watchdog counts system cycles between link clock edges
    if (sclk_rise) begin
      state_next.idle_cnt = 7'h00;
    end else if (state_reg.idle_cnt != tdm_err_pkg::STALL_CYC) begin
      state_next.idle_cnt = state_reg.idle_cnt + 7'h01;
    end

    // Frame sequencer
    case (state_reg.fr_state)
      tdm_err_pkg::FR_WAIT: begin
        // Extra clocks after the period produce nothing
        if (sclk_rise && fs_hi) begin
          state_next.frame_start = 1'b1;
          state_next.frame_cnt = state_reg.frame_cnt + 24'h000001;
          state_next.bit_cnt = 10'h000;
          state_next.dly_cnt = state_reg.gctrl[tdm_err_pkg::DELAY_LSB +: 4];
          state_next.fr_state = (state_reg.gctrl[tdm_err_pkg::DELAY_LSB +: 4] == 4'h0) ?
                                tdm_err_pkg::FR_RUN : tdm_err_pkg::FR_DELAY;
        end
      end
      tdm_err_pkg::FR_DELAY: begin
        if (state_reg.idle_cnt == tdm_err_pkg::STALL_CYC) begin
          state_next.fr_state = tdm_err_pkg::FR_STALL;
        end else if (sclk_rise) begin
          state_next.dly_cnt = state_reg.dly_cnt - 4'h1;
          if (state_reg.dly_cnt == 4'h1) begin
            state_next.fr_state = tdm_err_pkg::FR_RUN;
          end
        end
      end
      tdm_err_pkg::FR_RUN: begin
        if (state_reg.idle_cnt == tdm_err_pkg::STALL_CYC) begin
          state_next.fr_state = tdm_err_pkg::FR_STALL;
        end else if (sclk_rise) begin
          if (state_reg.bit_cnt[2:0] == 3'h7) begin
            state_next.slot_tick = 1'b1;
          end
          // Syncs before the last bit are ignored
          if (state_reg.bit_cnt != tdm_err_pkg::LAST_BIT) begin
            state_next.bit_cnt = state_reg.bit_cnt + 10'h001;
          end else if (fs_hi) begin
            state_next.frame_start = 1'b1;
            state_next.frame_cnt = state_reg.frame_cnt + 24'h000001;
            state_next.bit_cnt = 10'h000;
            state_next.dly_cnt = state_reg.gctrl[tdm_err_pkg::DELAY_LSB +: 4];
            state_next.fr_state = (state_reg.gctrl[tdm_err_pkg::DELAY_LSB +: 4] == 4'h0) ?
                                  tdm_err_pkg::FR_RUN : tdm_err_pkg::FR_DELAY;
          end else begin
            state_next.fr_state = tdm_err_pkg::FR_WAIT;
          end
        end
      end
      tdm_err_pkg::FR_STALL: begin
        // Clock came back: finish the broken frame as corrupt
        if (sclk_rise) begin
          state_next.corrupt = 1'b1;
          state_next.fr_state = tdm_err_pkg::FR_RECOVER;
        end
      end
      tdm_err_pkg::FR_RECOVER: begin
        // Syncs ignored until the period is used up
        if (state_reg.idle_cnt == tdm_err_pkg::STALL_CYC) begin
          state_next.fr_state = tdm_err_pkg::FR_STALL;
        end else if (sclk_rise) begin
          if (state_reg.bit_cnt == tdm_err_pkg::LAST_BIT) begin
            state_next.corrupt = 1'b0;
            state_next.fr_state = tdm_err_pkg::FR_WAIT;
          end else begin
            state_next.bit_cnt = state_reg.bit_cnt + 10'h001;
          end
        end
      end
      default: begin
        state_next.fr_state = tdm_err_pkg::FR_WAIT;
      end
    endcase

    // Global control and status
    if (wr_en && addr == tdm_err_pkg::ADDR_GCTRL) begin
      state_next.gctrl = wr_data[7:0];
    end
    if (rd_en && addr == tdm_err_pkg::ADDR_GCTRL) begin
      state_next.rd_data = {24'h000000, state_reg.gctrl};
    end
    if (rd_en && addr == tdm_err_pkg::ADDR_GSTAT) begin
      state_next.rd_data = {28'h0000000, state_reg.corrupt, state_reg.fr_state};
    end

    // Error queues
    for (int c = 0; c < tdm_err_pkg::NUM_CH; c++) begin
      base = 8'(tdm_err_pkg::CH_BASE + c * tdm_err_pkg::CH_STRIDE);
      err = pick_err(ch_status[c], state_reg.frame_start, xfer, xfer.ch == 1'(c), state_reg.frame_cnt);
      has_err = err.code != tdm_err_pkg::ERR_NONE;
      // Pop only by a write to the top location
      pop = wr_en && addr == base + tdm_err_pkg::OFS_QTOP && state_reg.q[c].count != 5'h00;
      push = has_err && !state_reg.q[c].ovf && state_reg.q[c].count != tdm_err_pkg::Q_FULL;
      wr_idx = state_reg.q[c].rd_ptr + state_reg.q[c].count[3:0];
      if (push) begin
        state_next.q[c].mem[wr_idx] = err;
      end
      if (pop) begin
        state_next.q[c].rd_ptr = state_reg.q[c].rd_ptr + 4'h1;
      end
      state_next.q[c].count = state_reg.q[c].count + {4'h0, push} - {4'h0, pop};
      // New drop at a full queue beats a same-cycle software clear
      if (wr_en && addr == base + tdm_err_pkg::OFS_QCTRL && wr_data[tdm_err_pkg::OVF_BIT]) begin
        state_next.q[c].ovf = 1'b0;
      end
      if (has_err && state_reg.q[c].count == tdm_err_pkg::Q_FULL) begin
        state_next.q[c].ovf = 1'b1;
      end
      state_next.q[c].irq = state_next.q[c].count != 5'h00 || state_next.q[c].ovf;
      if (rd_en && addr == base + tdm_err_pkg::OFS_QCTRL) begin
        state_next.rd_data = {31'h00000000, state_reg.q[c].ovf};
      end
      if (rd_en && addr == base + tdm_err_pkg::OFS_QCOUNT) begin
        state_next.rd_data = {27'h0000000, state_reg.q[c].count};
      end
      if (rd_en && addr == base + tdm_err_pkg::OFS_QTOP) begin
        // Empty queue reads as all zero
        state_next.rd_data = (state_reg.q[c].count == 5'h00) ? 32'h0000_0000 :
                             state_reg.q[c].mem[state_reg.q[c].rd_ptr];
      end
    end

    // Endian packing; the mapping is its own inverse, so it also unpacks
    if (pack_in.req) begin
      state_next.pack_vld = 1'b1;
      state_next.pack_out = pack_in.data;
      if (state_reg.gctrl[tdm_err_pkg::ENDIAN_BIT]) begin
        if (pack_in.kind == tdm_err_pkg::PK_BYTES) begin
          state_next.pack_out = {pack_in.data[7:0], pack_in.data[15:8],
                                 pack_in.data[23:16], pack_in.data[31:24]};
        end else if (pack_in.kind == tdm_err_pkg::PK_HALVES) begin
          state_next.pack_out = {pack_in.data[15:0], pack_in.data[31:16]};
        end
      end
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= '0;
      state_reg.fr_state <= tdm_err_pkg::FR_WAIT;
      state_reg.gctrl <= tdm_err_pkg::GCTRL_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state register
  assign rd_data = state_reg.rd_data;
  assign pack_out = state_reg.pack_out;
  assign pack_vld = state_reg.pack_vld;
  assign frame_start = state_reg.frame_start;
  assign slot_tick = state_reg.slot_tick;
  assign data_corrupt = state_reg.corrupt;
  always_comb begin
    for (int c = 0; c < tdm_err_pkg::NUM_CH; c++) begin
      err_irq[c] = state_reg.q[c].irq;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  count_bound_a: assert property (state_reg.q[0].count <= tdm_err_pkg::Q_FULL)
    else $error("queue count above depth");
  bus_ok_a: assert property (xfer.done && xfer.status == 3'h0 && !ch_status[0].tx_fetch_vld
      && !ch_status[0].rx_store_req && !ch_status[0].tx_load_req && !ch_status[0].rx_cid_bad
      && !state_reg.frame_start && !wr_en |=> state_reg.q[0].count == $past(state_reg.q[0].count))
    else $error("zero bus status created an entry");
  top_keep_a: assert property (rd_en && !wr_en && !xfer.done && !state_reg.frame_start
      && !ch_status[0].tx_fetch_vld && !ch_status[0].rx_store_req && !ch_status[0].tx_load_req
      && !ch_status[0].rx_cid_bad |=> $stable(state_reg.q[0].count))
    else $error("read changed queue count");
  pop_dec_a: assert property (wr_en && addr == tdm_err_pkg::CH_BASE + tdm_err_pkg::OFS_QTOP
      && state_reg.q[0].count != 5'h00 && state_reg.q[0].ovf
      |=> state_reg.q[0].count == $past(state_reg.q[0].count) - 5'h01)
    else $error("write to top did not pop");
  empty_zero_a: assert property (rd_en && addr == tdm_err_pkg::CH_BASE + tdm_err_pkg::OFS_QTOP
      && state_reg.q[0].count == 5'h00 |=> rd_data == 32'h0000_0000)
    else $error("empty top read not zero");
  full_ovf_a: assert property (state_reg.q[0].count == tdm_err_pkg::Q_FULL && xfer.done && !xfer.ch
      && xfer.status != 3'h0 |=> state_reg.q[0].ovf && state_reg.q[0].count != 5'h00)
    else $error("full queue did not flag overflow");
  ovf_hold_a: assert property (state_reg.q[0].ovf && !wr_en |=> state_reg.q[0].ovf
      && state_reg.q[0].count <= $past(state_reg.q[0].count))
    else $error("entry accepted while overflowed");
  irq_level_a: assert property (state_reg.q[0].count != 5'h00 && !wr_en ##1 !wr_en |-> err_irq[0])
    else $error("interrupt low with queued errors");
  early_sync_a: assert property (state_reg.fr_state == tdm_err_pkg::FR_RUN
      && state_reg.bit_cnt < tdm_err_pkg::LAST_BIT |=> !frame_start)
    else $error("early sync started a frame");
  late_quiet_a: assert property (state_reg.fr_state == tdm_err_pkg::FR_WAIT |=> !slot_tick)
    else $error("slot event while waiting for sync");
  recover_sync_a: assert property (state_reg.fr_state == tdm_err_pkg::FR_RECOVER |=> !frame_start)
    else $error("sync honoured during recovery");
  sync_word_a: assert property (pack_in.req && pack_in.kind == tdm_err_pkg::PK_SYNC
      |=> pack_vld && pack_out == $past(pack_in.data))
    else $error("sync word altered by packing");

  frame_run_c: cover property (frame_start ##[1:1000] slot_tick);
  stall_c: cover property (state_reg.fr_state == tdm_err_pkg::FR_STALL ##[1:100] data_corrupt);
  overflow_c: cover property (state_reg.q[0].ovf ##1 !state_reg.q[0].ovf);
  pop_c: cover property (state_reg.q[0].count == 5'h02 ##[1:50] state_reg.q[0].count == 5'h01);

endmodule

// file: dv/tdm_link_model.sv
`timescale 1ns/1ps

// ==========================================================
// Serial link source: bit clock and frame sync
module tdm_link_model (
  // Link pins
  output logic ser_clk,
  output logic frame_sync
);
  // Clock parked low outside frames, sync inactive
  initial begin
    ser_clk = 1'b0;
    frame_sync = 1'b0;
  end

  // One 400 ns period per bit; offset keeps rises clear of the system edges
  task automatic bits(input int n, input int sync_at);
    #13;
    for (int i = 0; i < n; i++) begin
      frame_sync = (i == sync_at);
      #200 ser_clk = 1'b1;
      #200 ser_clk = 1'b0;
    end
    frame_sync = 1'b0;
  endtask
endmodule

// file: dv/tdm_err_recovery_test.sv
`timescale 1ns/1ps

`define CHK(what, exp, got) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("ERROR %s expected %0h seen %0h", what, exp, got); \
    end \
  end

// ==========================================================
// Bench for error queues, framing recovery and packer
module tdm_err_recovery_test;
  logic clk_sys, rst, wr_en, rd_en, ser_clk, frame_sync, pack_vld, frame_start, slot_tick, data_corrupt;
  logic [7:0] addr;
  logic [31:0] wr_data, rd_data, pack_out;
  tdm_err_pkg::ch_in_t [tdm_err_pkg::NUM_CH-1:0] ch_status;
  tdm_err_pkg::xfer_t xfer;
  tdm_err_pkg::pack_t pack_in;
  logic [tdm_err_pkg::NUM_CH-1:0] err_irq;
  int error_cnt = 0;
  int n_checks = 0;
  int fs_cnt = 0;
  int tick_cnt = 0;
  tdm_err_pkg::entry_t expq[$];

  tdm_err_recovery tdm_err_recovery_i (.clk_sys(clk_sys), .rst(rst), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .ser_clk(ser_clk), .frame_sync(frame_sync),
    .ch_status(ch_status), .xfer(xfer), .pack_in(pack_in), .pack_out(pack_out), .pack_vld(pack_vld),
    .frame_start(frame_start), .slot_tick(slot_tick), .data_corrupt(data_corrupt), .err_irq(err_irq));
  tdm_link_model tdm_link_model_i (.ser_clk(ser_clk), .frame_sync(frame_sync));

  // 20 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Pulse counters; outputs are registers so the edge value is settled
  always @(posedge clk_sys) begin
    fs_cnt += (frame_start === 1'b1);
    tick_cnt += (slot_tick === 1'b1);
  end

  // ==========================================================
  // Helpers
  function automatic tdm_err_pkg::ch_in_t clean_ch();
    tdm_err_pkg::ch_in_t c;
    c = '0;
    c.rx_size = 8'h40;
    c.tx_size = 8'h40;
    c.rx_need = 8'h10;
    c.tx_need = 8'h10;
    c.active_id = 8'h5a;
    c.tx_fetched_id = 8'h5a;
    return c;
  endfunction

  function automatic logic [7:0] chaddr(input int c, input logic [7:0] ofs);
    return tdm_err_pkg::CH_BASE + tdm_err_pkg::CH_STRIDE * 8'(c) + ofs;
  endfunction

  task automatic do_reset();
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    @(negedge clk_sys);
    d = rd_data;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    reg_rd(a, d);
    `CHK(what, exp, d)
  endtask

  task automatic bus_ev(input logic w, input logic c, input logic [2:0] st);
    @(posedge clk_sys);
    xfer <= '{done: 1'b1, write: w, ch: c, status: st};
    @(posedge clk_sys);
    xfer <= '0;
  endtask

  task automatic ch_ev(input int c, input tdm_err_pkg::ch_in_t v);
    @(posedge clk_sys);
    ch_status[c] <= v;
    @(posedge clk_sys);
    ch_status[c] <= clean_ch();
  endtask

  // Interrupt service: count, then inspect and pop each entry
  task automatic drain(input int c);
    rd_chk("count", chaddr(c, tdm_err_pkg::OFS_QCOUNT), 32'(expq.size()));
    foreach (expq[i]) begin
      rd_chk("top", chaddr(c, tdm_err_pkg::OFS_QTOP), expq[i]);
      rd_chk("top kept", chaddr(c, tdm_err_pkg::OFS_QTOP), expq[i]);
      reg_wr(chaddr(c, tdm_err_pkg::OFS_QTOP), 32'h0);
    end
    expq.delete();
    rd_chk("count empty", chaddr(c, tdm_err_pkg::OFS_QCOUNT), 32'h0);
    rd_chk("top empty", chaddr(c, tdm_err_pkg::OFS_QTOP), 32'h0);
  endtask

  task automatic wait_fs(input int target);
    for (int i = 0; i < 40 && fs_cnt < target; i++) @(negedge clk_sys);
    `CHK("frame starts", target, fs_cnt)
    if (fs_cnt < target) close_out();
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs();
    rd_chk("gctrl", tdm_err_pkg::ADDR_GCTRL, 32'(tdm_err_pkg::GCTRL_RESET));
    reg_wr(8'hf0, 32'hffffffff);
    rd_chk("unmapped", 8'hf0, 32'h0);
    rd_chk("ctrl", chaddr(0, tdm_err_pkg::OFS_QCTRL), 32'h0);
    drain(0);
    $display("test regs done");
  endtask

  // Zero status makes no entry; every read and write code in order
  task automatic t_bus();
    bus_ev(1'b0, 1'b0, 3'h0);
    for (int s = 1; s < 8; s++) begin
      bus_ev(1'b0, 1'b0, 3'(s));
      expq.push_back({tdm_err_pkg::ERR_RD_BASE + 8'(s), 24'h0});
      bus_ev(1'b1, 1'b0, 3'(s));
      expq.push_back({tdm_err_pkg::ERR_WR_BASE + 8'(s), 24'h0});
    end
    @(negedge clk_sys);
    `CHK("irq raised", 2'b01, err_irq)
    drain(0);
    @(negedge clk_sys);
    `CHK("irq cleared", 2'b00, err_irq)
    $display("test bus done");
  endtask

  task automatic t_chan();
    tdm_err_pkg::ch_in_t v;
    v = clean_ch();
    v.tx_fetch_vld = 1'b1;
    v.tx_fetched_id = 8'h3c;
    ch_ev(1, v);
    expq.push_back({8'h10, 24'h005a3c});
    v = clean_ch();
    v.rx_cid_bad = 1'b1;
    ch_ev(1, v);
    expq.push_back({8'h03, 24'h5a});
    v = clean_ch();
    v.rx_full = 1'b1;
    v.rx_store_req = 1'b1;
    ch_ev(1, v);
    expq.push_back({8'h02, 24'h0});
    v = clean_ch();
    v.tx_empty = 1'b1;
    v.tx_load_req = 1'b1;
    ch_ev(1, v);
    expq.push_back({8'h12, 24'h0});
    drain(1);
    $display("test chan done");
  endtask

  // Channel 0 so that the queue assertions see overflow, pop and clear
  task automatic t_ovf();
    for (int i = 0; i < 17; i++) bus_ev(1'b1, 1'b0, 3'h2);
    rd_chk("full count", chaddr(0, tdm_err_pkg::OFS_QCOUNT), 32'(tdm_err_pkg::Q_FULL));
    rd_chk("ovf set", chaddr(0, tdm_err_pkg::OFS_QCTRL), 32'h1);
    reg_wr(chaddr(0, tdm_err_pkg::OFS_QTOP), 32'h0);
    bus_ev(1'b1, 1'b0, 3'h2);
    rd_chk("drop on ovf", chaddr(0, tdm_err_pkg::OFS_QCOUNT), 32'd15);
    reg_wr(chaddr(0, tdm_err_pkg::OFS_QCTRL), 32'h1);
    rd_chk("ovf clear", chaddr(0, tdm_err_pkg::OFS_QCTRL), 32'h0);
    bus_ev(1'b1, 1'b0, 3'h2);
    rd_chk("push again", chaddr(0, tdm_err_pkg::OFS_QCOUNT), 32'd16);
    $display("test ovf done");
  endtask

  // One fault per frame start; reset returns framing to waiting for sync
  task automatic t_start();
    tdm_err_pkg::ch_in_t v;
    logic [31:0] d;
    int f0;
    logic [7:0] codes [6] = '{8'h01, 8'h11, 8'h05, 8'h03, 8'h15, 8'h13};
    for (int i = 0; i < 6; i++) begin
      do_reset();
      v = clean_ch();
      v.rx_nonempty = (i == 0);
      v.tx_empty = (i == 1);
      v.rx_size = (i == 2) ? 8'h04 : 8'h40;
      v.rx_need = (i == 3) ? 8'h50 : 8'h10;
      v.tx_size = (i == 4) ? 8'h04 : 8'h40;
      v.tx_need = (i == 5) ? 8'h50 : 8'h10;
      @(posedge clk_sys);
      ch_status[1] <= v;
      // Start pulse is already counted when the link call returns
      f0 = fs_cnt;
      tdm_link_model_i.bits(1, 0);
      wait_fs(f0 + 1);
      repeat (3) @(negedge clk_sys);
      `CHK("irq channel", 2'b10, err_irq)
      @(posedge clk_sys);
      ch_status[1] <= clean_ch();
      reg_rd(chaddr(1, tdm_err_pkg::OFS_QTOP), d);
      `CHK("start code", codes[i], d[31:24])
      `CHK("start info", (i > 1) ? 24'h00005a : 24'h000001, d[23:0])
      rd_chk("one entry", chaddr(1, tdm_err_pkg::OFS_QCOUNT), 32'h1);
    end
    $display("test start done");
  endtask

  task automatic pk(input logic [1:0] kind, input logic [31:0] exp);
    @(posedge clk_sys);
    pack_in <= '{req: 1'b1, kind: kind, data: 32'h44332211};
    @(posedge clk_sys);
    pack_in <= '0;
    @(negedge clk_sys);
    `CHK("pack valid", 1'b1, pack_vld)
    `CHK("pack word", exp, pack_out)
  endtask

  task automatic t_endian();
    reg_wr(tdm_err_pkg::ADDR_GCTRL, 32'h0);
    pk(tdm_err_pkg::PK_BYTES, 32'h44332211);
    pk(tdm_err_pkg::PK_HALVES, 32'h44332211);
    reg_wr(tdm_err_pkg::ADDR_GCTRL, 32'h1);
    rd_chk("endian bit", tdm_err_pkg::ADDR_GCTRL, 32'h1);
    pk(tdm_err_pkg::PK_BYTES, 32'h11223344);
    pk(tdm_err_pkg::PK_HALVES, 32'h22114433);
    pk(tdm_err_pkg::PK_SYNC, 32'h44332211);
    $display("test endian done");
  endtask

  // Last slot event of a frame comes on the edge that ends the frame
  task automatic t_link();
    int t0;
    int f0;
    do_reset();
    repeat (4) @(posedge clk_sys);
    f0 = fs_cnt;
    tdm_link_model_i.bits(1, 0);
    t0 = tick_cnt;
    tdm_link_model_i.bits(1023, 500);
    repeat (8) @(negedge clk_sys);
    `CHK("early sync", f0 + 1, fs_cnt)
    `CHK("slots", t0 + 127, tick_cnt)
    tdm_link_model_i.bits(1, 0);
    wait_fs(f0 + 2);
    `CHK("last slot", t0 + 128, tick_cnt)
    tdm_link_model_i.bits(1024, -1);
    t0 = tick_cnt;
    tdm_link_model_i.bits(20, -1);
    rd_chk("wait state", tdm_err_pkg::ADDR_GSTAT, 32'h0);
    `CHK("no ticks", t0, tick_cnt)
    // Late sync with a programmed delay of two serial clocks
    f0 = fs_cnt;
    reg_wr(tdm_err_pkg::ADDR_GCTRL, 32'h20);
    tdm_link_model_i.bits(1, 0);
    wait_fs(f0 + 1);
    rd_chk("delay state", tdm_err_pkg::ADDR_GSTAT, 32'h1);
    tdm_link_model_i.bits(2, -1);
    rd_chk("run state", tdm_err_pkg::ADDR_GSTAT, 32'h2);
    t0 = fs_cnt;
    tdm_link_model_i.bits(99, -1);
    repeat (100) @(posedge clk_sys);
    rd_chk("stalled", tdm_err_pkg::ADDR_GSTAT, 32'h3);
    tdm_link_model_i.bits(1, 0);
    repeat (8) @(negedge clk_sys);
    `CHK("corrupt", 1'b1, data_corrupt)
    `CHK("sync ignored", t0, fs_cnt)
    // Returning edge is not a counted bit: 924 to reach bit 1023, one to leave
    tdm_link_model_i.bits(925, 400);
    repeat (8) @(negedge clk_sys);
    `CHK("corrupt end", 1'b0, data_corrupt)
    `CHK("recover sync", t0, fs_cnt)
    tdm_link_model_i.bits(1, 0);
    wait_fs(t0 + 1);
    $display("test link done");
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    addr = 8'h00;
    wr_data = 32'h0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    xfer = '0;
    pack_in = '0;
    ch_status = {clean_ch(), clean_ch()};
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_bus();
    t_chan();
    t_ovf();
    t_start();
    t_endian();
    t_link();
    close_out();
  end
endmodule
